// ### design/rst_idle_pkg.sv
package rst_idle_pkg;
   // register byte addresses (clock mode printed, others chosen)
   localparam logic [15:0] clock_mode_addr      = 16'h8C00;
   localparam logic [15:0] idle_control_addr    = 16'h8C04;
   localparam logic [15:0] idle_status_addr     = 16'h8C08;
   localparam logic [15:0] master_select_addr   = 16'h8C0C;
   localparam logic [15:0] periph_select_addr   = 16'h8C10;
   localparam logic [15:0] pll_control_addr     = 16'h8C14;
   localparam logic [15:0] wakeup_enable_addr   = 16'h8C18;
   localparam logic [15:0] boot_mode_addr       = 16'h8C1C;
   localparam logic [15:0] ext_bus_addr         = 16'h8C20;
   localparam logic [15:0] idle_cmd_addr        = 16'h8C24;
   // idle control field positions
   localparam int cpu_idle_pos      = 0;
   localparam int master_idle_pos   = 1;
   localparam int cache_idle_pos    = 2;
   localparam int periph_idle_pos   = 3;
   localparam int clock_idle_pos    = 4;
   localparam int memif_idle_pos    = 5;
   localparam int iport_idle_pos    = 6;
   localparam int icr_width         = 10;
   // master and peripheral select fields
   localparam int dma_sel_pos       = 0;
   localparam int host_sel_pos      = 1;
   localparam int memif_periph_pos  = 13;
   localparam int periph_sel_width  = 14;
   // pll control and wakeup enable fields
   localparam int pll_enable_pos    = 0;
   localparam int pll_powerdown_pos = 1;
   localparam int pll_reset_pos     = 2;
   localparam int osc_powerdown_pos = 3;
   localparam int wake_width        = 5;
   localparam logic [4:0] wake_reset_val = 5'h1F;
   localparam logic [3:0] pll_reset_val  = 4'h0;
   // reference clock period in ns, then timing in reference clock cycles
   localparam int clk_period_ns     = 10;
   localparam int osc_settle_cycles = 41032;
   localparam int propagate_cycles  = 70;
   localparam int count_width       = 16;
endpackage : rst_idle_pkg

// ### design/reset_and_idle_sequencer.sv
// Chosen here: the AXI4-Lite slave port.
`timescale 1ns/1ps
module reset_and_idle_sequencer
   import rst_idle_pkg::*;
(
   input  wire logic        core_clk,          // reference clock
   input  wire logic        sys_rst,           // reset pin, active high
   input  wire logic        clock_source_strap,// strap pin
   input  wire logic        parallel_mux_strap,// strap pin
   input  wire logic        serial_mux_strap,  // strap pin
   input  wire logic [2:0]  boot_mode_pins,    // boot mode pins
   input  wire logic [4:0]  wake_events,       // nmi, int0..int3 levels
   input  wire logic        dma_busy,          // dma transfer in progress
   input  wire logic [13:0] periph_busy,       // peripheral activity
   input  wire logic        interrupt_enable,  // external ints enabled by cpu
   input  wire logic [15:0] s_axi_awaddr,      // write address
   input  wire logic        s_axi_awvalid,     // write address valid
   output logic             s_axi_awready,     // write address ready
   input  wire logic [31:0] s_axi_wdata,       // write data
   input  wire logic [3:0]  s_axi_wstrb,       // byte strobes
   input  wire logic        s_axi_wvalid,      // write data valid
   output logic             s_axi_wready,      // write data ready
   output logic [1:0]       s_axi_bresp,       // write response
   output logic             s_axi_bvalid,      // write response valid
   input  wire logic        s_axi_bready,      // write response ready
   input  wire logic [15:0] s_axi_araddr,      // read address
   input  wire logic        s_axi_arvalid,     // read address valid
   output logic             s_axi_arready,     // read address ready
   output logic [31:0]      s_axi_rdata,       // read data
   output logic [1:0]       s_axi_rresp,       // read response
   output logic             s_axi_rvalid,      // read data valid
   input  wire logic        s_axi_rready,      // read data ready
   output logic             clock_source_select,// 1 external pin, 0 oscillator
   output logic             pll_bypass,        // clock generator bypassed
   output logic             core_reset,        // internal reset held
   output logic             run_enable,        // program execution allowed
   output logic             pins_float,        // tri-state the pad group
   output logic             pins_hold,         // freeze pads at last value
   output logic [5:0]       domain_gate,       // clock stopped per domain
   output logic             refresh_enable,    // sdram refresh allowed
   output logic             osc_powered_down,  // oscillator off
   output logic [1:0]       bus_mux_mode       // host, serial port 2 mux bits
);
   // one-hot sequencer states
   typedef enum logic [3:0] {
      st_reset  = 4'b0001,
      st_settle = 4'b0010,
      st_prop   = 4'b0100,
      st_run    = 4'b1000
   } seq_e;

   // sequencer state and its down counter
   seq_e             state_q;
   logic [15:0]      count_q;
   // two-flop synchroniser stages for every pin
   logic             rst_s1_q, rst_s2_q;
   logic [2:0]       strap_s1_q, strap_s2_q;
   logic [2:0]       boot_s1_q, boot_s2_q;
   logic [4:0]       wake_s1_q, wake_s2_q, wake_prev_q;
   logic [13:0]      pbusy_s1_q, pbusy_s2_q;
   logic             dbusy_s1_q, dbusy_s2_q;
   // release edge and wake restart tracking
   logic             rst_prev_q, osc_wake_q;
   // captured straps and boot pins
   logic             clk_sel_q;
   logic [1:0]       mux_q;
   logic [2:0]       boot_q;
   // software visible registers
   logic [icr_width-1:0]        icr_q, idle_status_register_q;
   logic [1:0]                  master_port_idle_select_q;
   logic [periph_sel_width-1:0] peripheral_idle_select_q;
   logic [3:0]                  pll_q;
   logic [wake_width-1:0]       wakeup_enable_register_q;
   // write channel holding stage
   logic             aw_hold_q, w_hold_q;
   logic [15:0]      aw_addr_q;
   logic [31:0]      w_data_q;
   logic [3:0]       w_strb_q;
   // decoded events shared by several processes
   logic             idle_cmd;
   logic [4:0]       wake_rise;
   logic             wake_hit;
   logic             release_edge;      // synced reset just dropped
   logic             write_fire;        // address and data both held
   logic             settle_done;       // settle count reached zero
   logic             prop_done;         // propagation count reached zero
   logic             master_ready;      // master port may stop its clock

   // apply byte strobes to a 16-bit register image
   function automatic logic [15:0] merge16(input logic [15:0] old, input logic [31:0] d, input logic [3:0] s);
      merge16 = {s[1] ? d[15:8] : old[15:8], s[0] ? d[7:0] : old[7:0]};
   endfunction : merge16

   // two-flop synchronisers for all pins
   // of these flops the logic below reads the second stages and prev copies; it also reads sys_rst raw as its reset
   always_ff @(posedge core_clk) begin
      rst_s1_q   <= sys_rst;
      rst_s2_q   <= rst_s1_q;
      strap_s1_q <= {serial_mux_strap, parallel_mux_strap, clock_source_strap};
      strap_s2_q <= strap_s1_q;
      boot_s1_q  <= boot_mode_pins;
      boot_s2_q  <= boot_s1_q;
      wake_s1_q  <= wake_events;
      wake_s2_q  <= wake_s1_q;
      pbusy_s1_q <= periph_busy;
      pbusy_s2_q <= pbusy_s1_q;
      dbusy_s1_q <= dma_busy;
      dbusy_s2_q <= dbusy_s1_q;
      rst_prev_q <= rst_s2_q;
      wake_prev_q <= wake_s2_q;
   end

   // straps caught on the clock after reset release
   always_ff @(posedge core_clk) begin
      if (release_edge) begin
         clk_sel_q <= strap_s2_q[0];
         mux_q     <= {strap_s2_q[1], strap_s2_q[2]};
      end else if (rst_s2_q) begin
         // while reset is held the source follows the strap pin
         clk_sel_q <= strap_s2_q[0];
         mux_q     <= mux_q;
      end else if (write_fire && aw_addr_q == clock_mode_addr && w_strb_q[0]) begin
         clk_sel_q <= w_data_q[0];
      end
   end

   // decoded events shared by several processes
   assign release_edge = rst_prev_q && !rst_s2_q;
   assign write_fire   = aw_hold_q && w_hold_q;
   assign settle_done  = state_q == st_settle && count_q == 16'h0000;
   assign prop_done    = state_q == st_prop && count_q == 16'h0000;
   // host idles at once; a busy dma keeps the master clock until it ends
   assign master_ready = (master_port_idle_select_q[host_sel_pos] || master_port_idle_select_q[dma_sel_pos]) &&
                         !(master_port_idle_select_q[dma_sel_pos] && dbusy_s2_q);

   // wake edges count only while the oscillator is down and the bit is clear
   assign wake_rise = wake_s2_q & ~wake_prev_q & ~wakeup_enable_register_q;
   assign wake_hit  = pll_q[osc_powerdown_pos] && idle_status_register_q[clock_idle_pos] &&
                      (wake_rise[0] || (|wake_rise[4:1] && interrupt_enable));

   // reset and wake sequencer
   always_ff @(posedge core_clk) begin
      if (sys_rst) begin
         state_q    <= st_reset;
         count_q    <= 16'h0000;
         osc_wake_q <= 1'b0;
      end else begin
         unique case (state_q)
            st_reset: if (release_edge) begin
               if (!strap_s2_q[0]) begin
                  state_q <= st_settle;
                  count_q <= 16'(osc_settle_cycles - 1);
               end else begin
                  state_q <= st_prop;
                  count_q <= 16'(propagate_cycles - 1);
               end
            end
            // settle count then propagation, or straight to run after a wake
            st_settle: if (count_q == 16'h0000) begin
               if (osc_wake_q) begin
                  state_q    <= st_run;
                  osc_wake_q <= 1'b0;
               end else begin
                  state_q <= st_prop;
                  count_q <= 16'(propagate_cycles - 1);
               end
            end else begin
               count_q <= count_q - 16'h0001;
            end
            st_prop: if (count_q == 16'h0000) begin
               state_q <= st_run;
            end else begin
               count_q <= count_q - 16'h0001;
            end
            // a wake restarts the oscillator count but skips propagation
            st_run: if (wake_hit) begin
               state_q    <= st_settle;
               count_q    <= 16'(osc_settle_cycles - 1);
               osc_wake_q <= 1'b1;
            end
         endcase
      end
   end

   // boot pins captured when the propagation count expires
   always_ff @(posedge core_clk) begin
      if (sys_rst) begin
         boot_q <= 3'h0;
      end else if (prop_done) begin
         boot_q <= boot_s2_q;
      end
   end

   // write channel: capture address and data in either order
   always_ff @(posedge core_clk) begin
      if (sys_rst) begin
         aw_hold_q    <= 1'b0;
         w_hold_q     <= 1'b0;
         s_axi_bvalid <= 1'b0;
         aw_addr_q    <= 16'h0000;
         w_data_q     <= 32'h0000_0000;
         w_strb_q     <= 4'h0;
      end else begin
         if (s_axi_awvalid && s_axi_awready) begin
            aw_hold_q <= 1'b1;
            aw_addr_q <= s_axi_awaddr;
         end
         if (s_axi_wvalid && s_axi_wready) begin
            w_hold_q <= 1'b1;
            w_data_q <= s_axi_wdata;
            w_strb_q <= s_axi_wstrb;
         end
         // the response rises the cycle after both halves are held
         if (write_fire) begin
            aw_hold_q    <= 1'b0;
            w_hold_q     <= 1'b0;
            s_axi_bvalid <= 1'b1;
         end else if (s_axi_bvalid && s_axi_bready) begin
            s_axi_bvalid <= 1'b0;
         end
      end
   end
   // readies drop while a write is held or answered
   assign s_axi_awready = !aw_hold_q && !s_axi_bvalid;
   assign s_axi_wready  = !w_hold_q && !s_axi_bvalid;
   assign s_axi_bresp   = 2'h0;
   assign idle_cmd      = write_fire && aw_addr_q == idle_cmd_addr;

   // software registers
   always_ff @(posedge core_clk) begin
      if (sys_rst) begin
         icr_q  <= '0;
         master_port_idle_select_q <= 2'h0;
         peripheral_idle_select_q <= '0;
         pll_q  <= pll_reset_val;
         wakeup_enable_register_q <= wake_reset_val;
      end else begin
         if (write_fire) begin
            unique case (aw_addr_q)
               idle_control_addr:  icr_q  <= icr_width'(merge16(16'(icr_q), w_data_q, w_strb_q));
               master_select_addr: master_port_idle_select_q <= 2'(merge16(16'(master_port_idle_select_q), w_data_q, w_strb_q));
               periph_select_addr: peripheral_idle_select_q <= periph_sel_width'(merge16(16'(peripheral_idle_select_q), w_data_q, w_strb_q));
               wakeup_enable_addr: wakeup_enable_register_q <= wake_width'(merge16(16'(wakeup_enable_register_q), w_data_q, w_strb_q));
               pll_control_addr:   pll_q  <= 4'(merge16(16'(pll_q), w_data_q, w_strb_q));
               default: ;
            endcase
         end
         // a wake in the same cycle as a write still clears the power-down bit
         if (wake_hit) begin
            pll_q[osc_powerdown_pos] <= 1'b0;
         end
      end
   end

   // idle status loaded by the idle command, cleared on wake
   always_ff @(posedge core_clk) begin
      if (sys_rst) begin
         idle_status_register_q <= '0;
      end else if (idle_cmd) begin
         idle_status_register_q <= icr_q;
      end else if (wake_hit || (settle_done && osc_wake_q)) begin
         idle_status_register_q <= '0;
      end
   end

   // domain clock gates driven from the status copy
   always_comb begin
      domain_gate[0] = idle_status_register_q[cpu_idle_pos];
      domain_gate[1] = idle_status_register_q[master_idle_pos] && master_ready;
      domain_gate[2] = idle_status_register_q[cache_idle_pos];
      domain_gate[3] = idle_status_register_q[periph_idle_pos] && |(peripheral_idle_select_q & ~pbusy_s2_q);
      domain_gate[4] = idle_status_register_q[clock_idle_pos];
      // memory interface waits for the dma, via cpu group or peripheral select
      domain_gate[5] = !dbusy_s2_q &&
                       ((idle_status_register_q[memif_idle_pos] && idle_status_register_q[cpu_idle_pos]) ||
                        (idle_status_register_q[periph_idle_pos] && peripheral_idle_select_q[memif_periph_pos]));
   end

   // outward controls decoded from state and status
   assign refresh_enable      = !domain_gate[5];
   assign clock_source_select = clk_sel_q;
   assign pll_bypass          = rst_s2_q || state_q != st_run || !pll_q[pll_enable_pos];
   // a wake restart stops execution but does not reset the core
   assign core_reset          = state_q != st_run && !osc_wake_q;
   assign run_enable          = state_q == st_run;
   // pads float through the reset counts and freeze while clock idle is in the status or across a wake
   assign pins_float          = state_q == st_reset || (state_q != st_run && !osc_wake_q);
   assign pins_hold           = idle_status_register_q[clock_idle_pos] || osc_wake_q;
   assign osc_powered_down    = pll_q[osc_powerdown_pos] && idle_status_register_q[clock_idle_pos];
   assign bus_mux_mode        = mux_q;

   // read channel, one cycle to answer
   always_ff @(posedge core_clk) begin
      if (sys_rst) begin
         s_axi_rvalid <= 1'b0;
         s_axi_rdata  <= 32'h0000_0000;
      end else if (s_axi_arvalid && s_axi_arready) begin
         s_axi_rvalid <= 1'b1;
         // narrow registers read back zero-extended
         unique case (s_axi_araddr)
            clock_mode_addr:    s_axi_rdata <= {31'h0, clk_sel_q};
            idle_control_addr:  s_axi_rdata <= 32'(icr_q);
            idle_status_addr:   s_axi_rdata <= 32'(idle_status_register_q);
            master_select_addr: s_axi_rdata <= 32'(master_port_idle_select_q);
            periph_select_addr: s_axi_rdata <= 32'(peripheral_idle_select_q);
            pll_control_addr:   s_axi_rdata <= 32'(pll_q);
            wakeup_enable_addr: s_axi_rdata <= 32'(wakeup_enable_register_q);
            boot_mode_addr:     s_axi_rdata <= 32'(boot_q);
            ext_bus_addr:       s_axi_rdata <= 32'(mux_q);
            default:            s_axi_rdata <= 32'h0000_0000;
         endcase
      end else if (s_axi_rvalid && s_axi_rready) begin
         s_axi_rvalid <= 1'b0;
      end
   end
   // one read in flight: no new address while data waits
   assign s_axi_arready = !s_axi_rvalid;
   assign s_axi_rresp   = 2'h0;
endmodule : reset_and_idle_sequencer

// ### verification/rst_idle_sva.sv
`timescale 1ns/1ps
module rst_idle_sva (
   input wire logic        core_clk,            // clock
   input wire logic        sys_rst,             // reset
   input wire logic        s_axi_bvalid,        // write resp valid
   input wire logic        s_axi_bready,        // write resp ready
   input wire logic [1:0]  s_axi_bresp,         // write resp
   input wire logic        s_axi_rvalid,        // read valid
   input wire logic        s_axi_rready,        // read ready
   input wire logic [31:0] s_axi_rdata,         // read data
   input wire logic        clock_source_select, // source bit
   input wire logic        pll_bypass,          // bypass
   input wire logic        core_reset,          // internal reset
   input wire logic        run_enable,          // execution
   input wire logic        pins_float,          // pads floating
   input wire logic        pins_hold,           // pads frozen
   input wire logic [5:0]  domain_gate,         // gated domains
   input wire logic        refresh_enable,      // refresh allowed
   input wire logic        osc_powered_down     // oscillator off
);
   localparam int prop_n = 70;
   localparam int osc_n  = 41102;
   localparam int wake_n = 41032;
   logic [15:0] rcnt_q;
   logic        boot_q;
   logic [15:0] wcnt_q;
   logic        waking_q;
   default clocking cb @(posedge core_clk); endclocking
   default disable iff (sys_rst);
   // cycles since reset release, until the first run
   always_ff @(posedge core_clk) begin
      if (sys_rst) begin
         rcnt_q <= 16'h0000;
         boot_q <= 1'b1;
      end else begin
         rcnt_q <= rcnt_q + 16'h0001;
         if (run_enable) boot_q <= 1'b0;
      end
   end
   // cycles since the oscillator restarted
   always_ff @(posedge core_clk) begin
      if (sys_rst || run_enable) begin
         waking_q <= 1'b0;
         wcnt_q   <= 16'h0000;
      end else if ($fell(osc_powered_down)) begin
         waking_q <= 1'b1;
         wcnt_q   <= 16'h0001;
      end else if (waking_q) wcnt_q <= wcnt_q + 16'h0001;
   end
   a_float_in_reset: assert property (core_reset |-> pins_float && pll_bypass)
      else $error("pads driven while held in reset");
   a_run_after_reset: assert property (run_enable |-> !core_reset)
      else $error("running while in reset");
   a_hold_no_float: assert property (pins_hold |-> !pins_float)
      else $error("pads float in power-down");
   a_memif_refresh: assert property (domain_gate[5] |-> !refresh_enable)
      else $error("refresh with memory interface idle");
   a_reset_count: assert property (boot_q && run_enable |->
      rcnt_q >= (clock_source_select ? prop_n : osc_n) && rcnt_q <= (clock_source_select ? prop_n : osc_n) + 8)
      else $error("run starts at wrong count after reset");
   a_wake_count: assert property (waking_q && run_enable |-> wcnt_q >= wake_n - 2 && wcnt_q <= wake_n + 6)
      else $error("run resumes at wrong count after wake");
   a_bresp_stand: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
      else $error("write response dropped");
   a_rdata_stand: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
      else $error("read data dropped");
   c_run: cover property ($rose(run_enable));
   c_osc_down: cover property ($rose(osc_powered_down));
   c_cpu_idle: cover property ($rose(domain_gate[0]));
endmodule : rst_idle_sva

// ### verification/board_model.sv
`timescale 1ns/1ps
module board_model (
   input wire logic       core_clk,           // clock
   input wire logic [5:0] strap_cfg,          // src, par, ser, boot
   input wire logic [4:0] wake_req,           // edge requests
   output logic           clock_source_strap, // strap
   output logic           parallel_mux_strap, // strap
   output logic           serial_mux_strap,   // strap
   output logic [2:0]     boot_mode_pins,     // boot pins
   output logic [4:0]     wake_events         // nmi, int0..int3
);
   logic [2:0] cnt_q;
   // straps stay level across reset release
   assign {clock_source_strap, parallel_mux_strap, serial_mux_strap, boot_mode_pins} = strap_cfg;
   // a request gives a clean low-to-high edge held five cycles
   always @(posedge core_clk) begin
      if (wake_req != 5'h00) begin
         wake_events <= wake_req;
         cnt_q       <= 3'h4;
      end else if (cnt_q != 3'h0) cnt_q <= cnt_q - 3'h1;
      else wake_events <= 5'h00;
   end
   initial cnt_q = 3'h0;
   initial wake_events = 5'h00;
endmodule : board_model

// ### verification/tb.sv
`timescale 1ns/1ps
`define CHK(nm, ex, got) begin checks_done++; if ((got) !== (ex)) begin errors++; \
   $display("wrong value %s exp %0h got %0h", nm, ex, got); end end
module tb;
   import rst_idle_pkg::*;
   logic core_clk = 1'b0, sys_rst = 1'b1, clock_source_strap, parallel_mux_strap, serial_mux_strap;
   logic [2:0] boot_mode_pins;
   logic [4:0] wake_events, wake_req;
   logic [5:0] strap_cfg, domain_gate;
   logic [13:0] periph_busy;
   logic dma_busy, interrupt_enable, s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid;
   logic s_axi_bready, s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready, clock_source_select;
   logic pll_bypass, core_reset, run_enable, pins_float, pins_hold, refresh_enable, osc_powered_down;
   logic [15:0] s_axi_awaddr, s_axi_araddr;
   logic [31:0] s_axi_wdata, s_axi_rdata, d;
   logic [3:0] s_axi_wstrb;
   logic [1:0] s_axi_bresp, s_axi_rresp, bus_mux_mode;
   int errors = 0, checks_done = 0, cyc = 0, n;
   reset_and_idle_sequencer u_reset_and_idle_sequencer (.*);
   board_model u_board_model (.*);
   always #5 core_clk = ~core_clk;
   // hang guard
   always @(posedge core_clk) begin
      cyc++;
      if (cyc == 90000) begin
         errors++;
         final_report();
      end
   end
   task automatic final_report();
      $display("checks %0d errors %0d", checks_done, errors);
      if (errors == 0 && checks_done > 0) $display("Testbench passed");
      else $display("Testbench failed");
      $finish;
   endtask : final_report
   // one write, address and data offered together
   task automatic wr(input logic [15:0] a, input logic [31:0] v);
      @(posedge core_clk);
      s_axi_awaddr <= a;
      s_axi_awvalid <= 1'b1;
      s_axi_wdata <= v;
      s_axi_wvalid <= 1'b1;
      s_axi_bready <= 1'b1;
      forever begin
         @(posedge core_clk);
         if (s_axi_awvalid && s_axi_awready) s_axi_awvalid <= 1'b0;
         if (s_axi_wvalid && s_axi_wready) s_axi_wvalid <= 1'b0;
         if (s_axi_bvalid === 1'b1) break;
      end
      s_axi_bready <= 1'b0;
      `CHK("bresp", 2'b00, s_axi_bresp)
   endtask : wr
   task automatic rd(input logic [15:0] a, output logic [31:0] v);
      @(posedge core_clk);
      s_axi_araddr <= a;
      s_axi_arvalid <= 1'b1;
      s_axi_rready <= 1'b1;
      forever begin
         @(posedge core_clk);
         if (s_axi_arvalid && s_axi_arready) s_axi_arvalid <= 1'b0;
         if (s_axi_rvalid === 1'b1) break;
      end
      v = s_axi_rdata;
      `CHK("rresp", 2'b00, s_axi_rresp)
      s_axi_rready <= 1'b0;
   endtask : rd
   task automatic wait_run(output int c);
      c = 0;
      while (run_enable !== 1'b1 && c < 50000) begin
         @(posedge core_clk);
         c++;
      end
   endtask : wait_run
   // load the idle control register, then issue the idle command
   task automatic idle(input logic [31:0] v);
      wr(idle_control_addr, v);
      wr(idle_cmd_addr, 32'h00000000);
      repeat (4) @(posedge core_clk);
   endtask : idle
   initial begin
      {strap_cfg, wake_req, dma_busy, periph_busy, interrupt_enable} = {6'h35, 5'h00, 1'b0, 14'h0000, 1'b0};
      {s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = 5'h00;
      {s_axi_awaddr, s_axi_araddr, s_axi_wdata, s_axi_wstrb} = {16'h0000, 16'h0000, 32'h00000000, 4'h3};
      repeat (3) @(posedge core_clk);
      `CHK("pins_float", 1'b1, pins_float)
      `CHK("pll_bypass", 1'b1, pll_bypass)
      `CHK("core_reset", 1'b1, core_reset)
      sys_rst <= 1'b0;
      wait_run(n);
      `CHK("short count", 1'b1, (n >= 70 && n <= 76))
      repeat (3) @(posedge core_clk);
      `CHK("pins_float", 1'b0, pins_float)
      `CHK("core_reset", 1'b0, core_reset)
      `CHK("source", 1'b1, clock_source_select)
      `CHK("bus_mux_mode", 2'b10, bus_mux_mode)
      rd(boot_mode_addr, d);
      `CHK("boot", 3'h5, d[2:0])
      rd(clock_mode_addr, d);
      `CHK("clock mode", 32'h00000001, d)
      wr(pll_control_addr, 32'h00000001);
      `CHK("pll run", 1'b0, pll_bypass)
      wr(clock_mode_addr, 32'h00000000);
      `CHK("source sw", 1'b0, clock_source_select)
      wr(16'h8C30, 32'hFFFFFFFF);
      rd(16'h8C30, d);
      `CHK("unmapped", 32'h00000000, d)
      idle(32'h00000001);
      rd(idle_status_addr, d);
      `CHK("status", 32'h00000001, d)
      `CHK("cpu gate", 1'b1, domain_gate[0])
      dma_busy <= 1'b1;
      wr(master_select_addr, 32'h00000003);
      idle(32'h00000067);
      `CHK("dma gate busy", 1'b0, domain_gate[1])
      `CHK("refresh busy", 1'b1, refresh_enable)
      dma_busy <= 1'b0;
      repeat (6) @(posedge core_clk);
      `CHK("dma gate", 1'b1, domain_gate[1])
      `CHK("memif gate", 1'b1, domain_gate[5])
      `CHK("refresh", 1'b0, refresh_enable)
      wr(periph_select_addr, 32'h00003FFF);
      idle(32'h0000006F);
      `CHK("light sleep", 6'h2F, domain_gate)
      wr(pll_control_addr, 32'h0000000E);
      `CHK("pll bypass", 1'b1, pll_bypass)
      wr(wakeup_enable_addr, 32'h0000001D);
      interrupt_enable <= 1'b1;
      idle(32'h000003FF);
      `CHK("osc down", 1'b1, osc_powered_down)
      `CHK("pins_hold", 1'b1, pins_hold)
      wake_req <= 5'h01;
      @(posedge core_clk);
      wake_req <= 5'h00;
      repeat (10) @(posedge core_clk);
      `CHK("masked wake", 1'b1, osc_powered_down)
      wake_req <= 5'h02;
      @(posedge core_clk);
      wake_req <= 5'h00;
      n = 0;
      while (osc_powered_down !== 1'b0 && n < 20) begin
         @(posedge core_clk);
         n++;
      end
      wait_run(n);
      `CHK("wake count", 1'b1, (n >= 41030 && n <= 41038))
      rd(pll_control_addr, d);
      `CHK("osc bit", 1'b0, d[osc_powerdown_pos])
      sys_rst <= 1'b1;
      strap_cfg <= 6'h0A;
      repeat (3) @(posedge core_clk);
      sys_rst <= 1'b0;
      wait_run(n);
      `CHK("long count", 1'b1, (n >= 41102 && n <= 41108))
      `CHK("source", 1'b0, clock_source_select)
      `CHK("bus_mux_mode", 2'b01, bus_mux_mode)
      final_report();
   end
endmodule : tb
bind reset_and_idle_sequencer rst_idle_sva u_rst_idle_sva (.*);
